/* pkg/bst_pkg.sv */
// Shared constants, states and carrier types of the boundary scan test port
package bst_pkg;

  // ***********************************************************
  // Controller states
  // ***********************************************************
  typedef enum logic [3:0] {
    st_reset, st_idle,
    st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr, st_pau_dr, st_ex2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir, st_pau_ir, st_ex2_ir, st_upd_ir
  } bst_state_t;

  // ***********************************************************
  // Instruction register and opcodes
  // ***********************************************************
  localparam int IR_W = 3;
  typedef logic [IR_W-1:0] bst_ir_t;

  localparam bst_ir_t OP_PIN_FLOAT = 3'h0;    // Pin capture, outputs floated
  localparam bst_ir_t OP_IDENT = 3'h1;        // Identification read
  localparam bst_ir_t OP_SAMPLE_FLOAT = 3'h2; // Boundary sample, outputs floated
  localparam bst_ir_t OP_RSVD_A = 3'h3;
  localparam bst_ir_t OP_SAMPLE = 3'h4;       // Boundary sample, memory untouched
  localparam bst_ir_t OP_RSVD_B = 3'h5;
  localparam bst_ir_t OP_RSVD_C = 3'h6;
  localparam bst_ir_t OP_BYPASS = 3'h7;

  // Pattern parallel-loaded into the two low stages at instruction capture
  localparam logic [1:0] IR_CAPTURE_PAT = 2'h1;
  localparam logic IR_CAPTURE_MSB = 1'h0;

  // ***********************************************************
  // Data register sizes
  // ***********************************************************
  localparam int ID_W = 32;
  localparam int ID_REV_W = 4;
  localparam int ID_DEV_W = 4;
  localparam int ID_TYPE_W = 6;
  localparam int ID_SIZE_W = 6;
  localparam int ID_MAKER_W = 12;
  localparam int BSR_LEN_X36 = 70;
  localparam int BSR_LEN_X18 = 51;
  localparam int BSR_MAX = 70;

  // Consecutive high mode-select samples that force the reset state
  localparam int RESET_TMS_EDGES = 5;
  localparam int TMS_RUN_W = 3;
  localparam int SYNC_W = 2;

  // ***********************************************************
  // Carrier types
  // ***********************************************************
  typedef struct packed {
    logic tms;
    logic tdi;
  } bst_link_in_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } bst_link_out_t;

  // Rising-edge state of the test-clock domain
  typedef struct packed {
    logic [SYNC_W-1:0] rst_sync;
    bst_state_t state;
    bst_ir_t ir_shift;
    bst_ir_t ir;
    logic bypass;
    logic [ID_W-1:0] idr;
    logic [BSR_MAX-1:0] bsr;
    logic [BSR_MAX-1:0] pin_meta;
    logic [BSR_MAX-1:0] pin_sync;
    logic [TMS_RUN_W-1:0] tms_run;
  } bst_tap_state_t;

  // State of the system-clock domain
  typedef struct packed {
    logic float_meta;
    logic float_sync;
  } bst_sys_state_t;

endpackage

/* sim/boundary_scan_tap_test.sv */
// Self-checking bench of the boundary scan test port
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_test;
  import bst_pkg::*;
  // Identity fields; values arbitrary
  localparam logic [3:0] REV = 4'h5;
  localparam logic [3:0] DEV = 4'h6;
  localparam logic [5:0] TYP = 6'h11;
  localparam logic [5:0] SIZ = 6'h22;
  localparam logic [11:0] MAK = 12'h0a5;
  localparam logic [69:0] PINS = 70'h2_5a5a_c3c3_0ff0_1234_5;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [BSR_MAX-1:0] pin_ring = '0;
  logic tck;
  logic mem_float;
  bst_link_in_t link_in;
  bst_link_out_t link_out;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [79:0] got;

  always #2 clock = ~clock;

  bst_tap #(.WIDE_X36(1'b1), .ID_REVISION(REV), .ID_DEVICE(DEV), .ID_TYPE(TYP),
    .ID_SIZE(SIZ), .ID_MAKER(MAK)) DUT (.clock(clock), .reset(reset), .tck(tck),
    .link_in(link_in), .link_out(link_out), .pin_ring(pin_ring), .mem_float(mem_float));

  bst_jtag_host host (.tck(tck), .link_out(link_out), .link_in(link_in));

  // ***********************************************************
  // Shared checking and closing
  // ***********************************************************
  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Cuts a hang short; a full run needs under 2000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  // Loads an instruction and checks the captured fault-isolation bits
  task automatic load_ir(input bst_ir_t code);
    host.scan(1'b1, 3, {77'h0, code}, got);
    check("ir capture", 2'h1, got[1:0]);
  endtask

  // ***********************************************************
  // Scenarios
  // ***********************************************************
  task automatic t_ident(input string name);
    check("oe idle", 1'b0, link_out.tdo_oe);
    host.scan(1'b0, 40, 80'hc5, got);
    check("ident", {REV, DEV, TYP, SIZ, MAK}, got[31:0]);
    check("ident tail", 8'hc5, got[39:32]);
    check("oe after shift", 1'b0, link_out.tdo_oe);
    $display("Test %s done", name);
  endtask

  // Bypass gives a one-bit path that starts cleared; reserved codes stay unused
  task automatic t_bypass();
    logic [8:0] pats[4] = '{9'h1a5, 9'h05a, 9'h1ff, 9'h100};
    foreach (pats[k]) begin
      load_ir(OP_BYPASS);
      host.scan(1'b0, 9, {71'h0, pats[k]}, got);
      check("bypass path", {pats[k][7:0], 1'b0}, got[8:0]);
      check("bypass float", 1'b0, mem_float);
    end
    $display("Test bypass done");
  endtask

  // Pin snapshot, full register length and output floating per code
  task automatic t_sample(input bst_ir_t code, input logic flt, input logic [69:0] pins);
    @(posedge clock);
    pin_ring <= pins;
    load_ir(code);
    repeat (8) @(posedge clock);
    check("float level", flt, mem_float);
    host.scan(1'b0, 78, 80'h96, got);
    check("pin snapshot", pins, got[69:0]);
    check("boundary length", 8'h96, got[77:70]);
    $display("Test sample %h done", code);
  endtask

  // Mode-select reset while outputs float restores the default instruction
  task automatic t_tap_reset();
    host.tap_reset();
    repeat (8) @(posedge clock);
    check("float after reset", 1'b0, mem_float);
    t_ident("ident after reset");
  endtask

  initial begin
    host.tap_reset(); // Clocks the reset into the test-clock domain
    @(posedge clock);
    reset <= 1'b0;
    host.tap_reset();
    check("float idle", 1'b0, mem_float);
    t_ident("ident");
    t_bypass();
    t_sample(OP_SAMPLE, 1'b0, PINS);
    t_sample(OP_PIN_FLOAT, 1'b1, ~PINS);
    t_sample(OP_SAMPLE_FLOAT, 1'b1, PINS);
    t_tap_reset();
    finish_test();
  end

endmodule
`default_nettype wire

/* sim/bst_jtag_host.sv */
// Board-side scan controller model that drives the test clock and serial lines
`timescale 1ns/1ps
`default_nettype none

module bst_jtag_host (
  output var logic tck,
  input wire bst_pkg::bst_link_out_t link_out,
  output var bst_pkg::bst_link_in_t link_in
);
  import bst_pkg::*;

  // Clock parked low between frames, lines at their pull-up level
  initial begin
    tck = 1'b0;
    link_in = '1;
  end

  // ***********************************************************
  // Frame tasks
  // ***********************************************************
  // One test-clock cycle; serial out is read just before the rise
  // Short 12 ns period keeps runs brief; the port has no minimum period
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    link_in.tms = tms;
    link_in.tdi = tdi;
    #6;
    tdo = link_out.tdo_oe ? link_out.tdo : 1'bx;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask

  // Five high mode-select rises, then on to run-idle
  task automatic tap_reset();
    logic d;
    #0.7;
    repeat (5) step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
    link_in = '1;
  endtask

  // Capture and shift n bits through the IR or DR path from run-idle
  task automatic scan(input bit ir, input int n, input logic [79:0] din,
                      output logic [79:0] dout);
    logic d;
    #0.7; // Keeps the test clock out of phase with the system clock
    dout = 'x;
    step(1'b1, 1'b1, d);
    if (ir) begin
      step(1'b1, 1'b1, d);
    end
    step(1'b0, 1'b1, d);
    step(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d); // Low bit first
      dout[i] = d;
    end
    step(1'b1, 1'b1, d); // Update, then idle
    step(1'b0, 1'b1, d);
    link_in = '1;
  endtask

endmodule
`default_nettype wire

/* src/bst_tap.sv */
// Boundary scan test access port with memory output float control
`timescale 1ns/1ps
`default_nettype none

module bst_tap #(
  parameter bit WIDE_X36 = 1'b1,
  parameter logic [bst_pkg::ID_REV_W-1:0] ID_REVISION = 4'h1,   // Value arbitrary
  parameter logic [bst_pkg::ID_DEV_W-1:0] ID_DEVICE = 4'h2,     // Value arbitrary
  parameter logic [bst_pkg::ID_TYPE_W-1:0] ID_TYPE = 6'h03,     // Value arbitrary
  parameter logic [bst_pkg::ID_SIZE_W-1:0] ID_SIZE = 6'h0a,     // Value arbitrary
  parameter logic [bst_pkg::ID_MAKER_W-1:0] ID_MAKER = 12'h0f3  // Value arbitrary
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic tck,
  input wire bst_pkg::bst_link_in_t link_in,
  output var bst_pkg::bst_link_out_t link_out,
  input wire logic [bst_pkg::BSR_MAX-1:0] pin_ring,
  output logic mem_float
);
  import bst_pkg::*;

  // ***********************************************************
  // Derived constants
  // ***********************************************************
  localparam int BSR_LEN = WIDE_X36 ? BSR_LEN_X36 : BSR_LEN_X18;
  localparam logic [BSR_MAX-1:0] BSR_MASK = {BSR_MAX{1'b1}} >> (BSR_MAX - BSR_LEN);
  localparam logic [ID_W-1:0] ID_VALUE = {ID_REVISION, ID_DEVICE, ID_TYPE, ID_SIZE,
                                          ID_MAKER};
  localparam logic [TMS_RUN_W-1:0] TMS_RUN_LIMIT = TMS_RUN_W'(RESET_TMS_EDGES);

  // ***********************************************************
  // Test-clock domain state
  // ***********************************************************
  bst_tap_state_t q;
  bst_tap_state_t d;
  bst_link_out_t out_q;
  bst_link_out_t out_d;
  bst_sys_state_t sys_q;
  bst_sys_state_t sys_d;
  logic tap_rst;
  logic shifting;
  logic sel_lsb;
  logic float_tck;
  logic pin_op;

  // Reset seen on the test clock after two flops
  assign tap_rst = q.rst_sync[SYNC_W-1];

  // Pin capture instructions, including the two floating ones
  assign pin_op = (q.ir == OP_PIN_FLOAT) || (q.ir == OP_SAMPLE_FLOAT) ||
                  (q.ir == OP_SAMPLE);

  // Floating instructions only; everything else leaves memory alone
  assign float_tck = (q.ir == OP_PIN_FLOAT) || (q.ir == OP_SAMPLE_FLOAT);

  assign shifting = (q.state == st_sh_ir) || (q.state == st_sh_dr);

  // Scan path multiplexer: one register at a time
  always_comb begin
    sel_lsb = q.bypass;
    if (q.state == st_sh_ir) begin
      sel_lsb = q.ir_shift[0];
    end else begin
      unique case (q.ir)
        OP_IDENT: begin
          sel_lsb = q.idr[0];
        end
        OP_PIN_FLOAT, OP_SAMPLE_FLOAT, OP_SAMPLE: begin
          sel_lsb = q.bsr[0];
        end
        default: begin
          sel_lsb = q.bypass; // Reserved codes fall back to bypass
        end
      endcase
    end
  end

  // Next state of the rising-edge domain
  always_comb begin
    d = q;
    // Reset and pin ring come from outside this clock, two flops each
    d.rst_sync = {q.rst_sync[0], reset};
    d.pin_meta = pin_ring;
    d.pin_sync = q.pin_meta;
    d.tms_run = link_in.tms ? ((q.tms_run == TMS_RUN_LIMIT) ? q.tms_run : q.tms_run + 1'b1)
                            : '0;

    // Controller sequencing on sampled mode select
    unique case (q.state)
      st_reset: d.state = link_in.tms ? st_reset : st_idle;
      st_idle: d.state = link_in.tms ? st_sel_dr : st_idle;
      st_sel_dr: d.state = link_in.tms ? st_sel_ir : st_cap_dr;
      st_cap_dr: d.state = link_in.tms ? st_ex1_dr : st_sh_dr;
      st_sh_dr: d.state = link_in.tms ? st_ex1_dr : st_sh_dr;
      st_ex1_dr: d.state = link_in.tms ? st_upd_dr : st_pau_dr;
      st_pau_dr: d.state = link_in.tms ? st_ex2_dr : st_pau_dr;
      st_ex2_dr: d.state = link_in.tms ? st_upd_dr : st_sh_dr;
      st_upd_dr: d.state = link_in.tms ? st_sel_dr : st_idle;
      st_sel_ir: d.state = link_in.tms ? st_reset : st_cap_ir;
      st_cap_ir: d.state = link_in.tms ? st_ex1_ir : st_sh_ir;
      st_sh_ir: d.state = link_in.tms ? st_ex1_ir : st_sh_ir;
      st_ex1_ir: d.state = link_in.tms ? st_upd_ir : st_pau_ir;
      st_pau_ir: d.state = link_in.tms ? st_ex2_ir : st_pau_ir;
      st_ex2_ir: d.state = link_in.tms ? st_upd_ir : st_sh_ir;
      st_upd_ir: d.state = link_in.tms ? st_sel_dr : st_idle;
    endcase

    // Register actions of the current state
    unique case (q.state)
      st_reset: begin
        d.ir = OP_IDENT;
      end
      st_cap_ir: begin
        d.ir_shift = {IR_CAPTURE_MSB, IR_CAPTURE_PAT};
      end
      st_sh_ir: begin
        d.ir_shift = {link_in.tdi, q.ir_shift[IR_W-1:1]};
      end
      st_upd_ir: begin
        d.ir = q.ir_shift;
      end
      st_cap_dr: begin
        if (q.ir == OP_IDENT) begin
          d.idr = ID_VALUE;
        end else if (pin_op) begin
          d.bsr = q.pin_sync & BSR_MASK;
        end else begin
          d.bypass = 1'b0;
        end
      end
      st_sh_dr: begin
        if (q.ir == OP_IDENT) begin
          d.idr = {link_in.tdi, q.idr[ID_W-1:1]};
        end else if (pin_op) begin
          // Bits above the configured length stay zero, so a plain shift works
          d.bsr = (q.bsr >> 1) | (BSR_MAX'(link_in.tdi) << (BSR_LEN - 1));
        end else begin
          d.bypass = link_in.tdi;
        end
      end
      default: begin
        // Data update leaves every register as a pause would
      end
    endcase

    // Tap reset from the system reset, applied on the third rising test-clock edge after reset rises
    if (tap_rst) begin
      d.state = st_reset;
      d.ir = OP_IDENT;
      d.ir_shift = '0;
      d.bypass = 1'b0;
      d.idr = '0;
      d.bsr = '0;
      d.tms_run = '0;
    end
  end

  // Rising-edge register of the test-clock domain
  always_ff @(posedge tck) begin
    q <= d;
  end

  // ***********************************************************
  // Serial output on the falling edge
  // ***********************************************************
  // Half a test clock of hold for the far end's rising-edge sample
  always_comb begin
    out_d.tdo = shifting ? sel_lsb : 1'b0;
    out_d.tdo_oe = shifting;
    if (tap_rst) begin
      out_d = '0;
    end
  end

  always_ff @(negedge tck) begin
    out_q <= out_d;
  end

  assign link_out = out_q;

  // ***********************************************************
  // Float request into the memory clock domain
  // ***********************************************************
  // Level crossing; the memory sees the float a few of its clocks late
  always_comb begin
    sys_d.float_meta = float_tck;
    sys_d.float_sync = sys_q.float_meta;
    if (reset) begin
      sys_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    sys_q <= sys_d;
  end

  // Only a float request leaves the port; no core data is ever driven
  assign mem_float = sys_q.float_sync;

  // ***********************************************************
  // Checks
  // ***********************************************************
  tms_reset_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.tms_run == TMS_RUN_LIMIT) |-> (q.state == st_reset))
    else $error("five high mode-select edges did not reach reset");

  ir_preset_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.state == st_reset) |=> (q.ir == OP_IDENT))
    else $error("instruction not preset to identification read");

  cap_ir_pattern_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.state == st_cap_ir) |=> (q.ir_shift[1:0] == IR_CAPTURE_PAT))
    else $error("instruction capture pattern wrong");

  ir_update_only_a: assert property (@(posedge tck) disable iff (tap_rst)
    !$stable(q.ir) |-> ($past(q.state) == st_upd_ir || $past(q.state) == st_reset))
    else $error("instruction changed outside update or reset");

  ir_shift_msb_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.state == st_sh_ir) |=> (q.ir_shift[IR_W-1] == $past(link_in.tdi)))
    else $error("instruction data did not enter at msb");

  // Split in two so an unknown state before the first reset stays vacuous
  tdo_enable_a: assert property (@(posedge tck) disable iff (tap_rst)
    shifting |-> out_q.tdo_oe)
    else $error("serial output not enabled in a shift state");

  tdo_float_a: assert property (@(posedge tck) disable iff (tap_rst)
    !shifting |-> !out_q.tdo_oe)
    else $error("serial output enabled outside shift states");

  id_capture_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.state == st_cap_dr && q.ir == OP_IDENT) |=> (q.idr == ID_VALUE))
    else $error("identification value not captured");

  bypass_clear_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.state == st_cap_dr && q.ir == OP_BYPASS) |=> (q.bypass == 1'b0))
    else $error("bypass bit not cleared at capture");

  bsr_capture_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.state == st_cap_dr && pin_op) |=> (q.bsr == ($past(q.pin_sync) & BSR_MASK)))
    else $error("boundary register did not snapshot pins");

  no_preload_a: assert property (@(posedge tck) disable iff (tap_rst)
    (q.state == st_upd_dr) |=> ($stable(q.bsr) && $stable(q.ir)))
    else $error("data update changed a register");

  mem_float_a: assert property (@(posedge clock) disable iff (reset)
    $rose(float_tck) |-> ##[1:3] mem_float)
    else $error("memory float did not follow instruction");

endmodule

`default_nettype wire
